// file: design/memctl_init_pkg.sv
// Constants, encodings and register layout for the memory controller
// reset and initialization block.
// Assumes one 100 MHz pclk and an APB master with 32-bit data.
package memctl_init_pkg;

   // Clock period; pclk follows both edges of the double-rate clock.
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PCLK_PER_SYS = 4;
   localparam int unsigned MEMORY_CLOCK_PER_SYS = 2;

   // Internal reset release stages and pin synchroniser depth.
   localparam int unsigned RST_STAGES = 4;
   localparam int unsigned PIN_RELEASE_STAGE = 2;

   // Phase positions of the internal edges within a system cycle.
   localparam logic [1:0] PH_CLK1R = 2'h0;
   localparam logic [1:0] PH_CLK2R = 2'h1;
   localparam logic [1:0] PH_CLK1F = 2'h2;
   localparam logic [1:0] PH_CLK2F = 2'h3;
   localparam logic [1:0] PH_AFTER_REF = 2'h3;
   localparam int unsigned EDGE_N = 5;
   localparam int unsigned E_CLK1R = 0;
   localparam int unsigned E_CLK1F = 1;
   localparam int unsigned E_CLK2R = 2;
   localparam int unsigned E_CLK2F = 3;
   localparam int unsigned E_MEMR = 4;

   // Register read returns after two system cycles.
   localparam logic [1:0] CSR_WAIT_LAST = 2'h1;

   // Refresh timing.
   localparam int unsigned REF_UNIT_MEMORY_CLOCK = 64;
   localparam int unsigned REF_UNIT_SYS = REF_UNIT_MEMORY_CLOCK / MEMORY_CLOCK_PER_SYS;
   localparam logic [1:0] REF_BUSY_LAST = 2'h1;
   localparam logic [7:0] INIT_REFRESHES = 8'h08;
   localparam logic [7:0] REF_CNT_MAX = 8'hFF;

   // Register offsets (byte addresses).
   localparam logic [7:0] ADDR_REF_TIMING = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   // Refresh timing register fields.
   localparam int unsigned FORCE_BIT = 0;
   localparam int unsigned IV_LSB = 1;
   localparam int unsigned IV_W = 6;
   localparam logic [5:0] IV_RST = 6'h10;
   localparam logic [10:0] TIMER_RST = 11'(IV_RST * REF_UNIT_SYS - 1);

   // Status register fields.
   localparam int unsigned CNT_LSB = 0;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned READY_BIT = 8;
   localparam int unsigned PD_BIT = 9;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b11
   } apb_st_e;

endpackage

// file: design/memctl_reset_init.sv
// Reset, clock phase and refresh start logic of the memory controller.
// Assumes an APB master on pclk and board pins that are asynchronous.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Five internal edges from clock and phase reference.
// - Register reads answer after two system cycles.
// - Internal reset asserts async, releases synchronously.
// - Refresh and presence-detect outputs inactive during reset.
// - Bidirectional pins float during reset.
// - Cache and tag strobes held, dropped at release.
// - Presence detect starts at internal release.
// - Memory bus drive active throughout reset.
// - Test tristate floats every output.
// - Tristate release restores reset-state pins.
// - Refreshes begin when internal reset ends.
// - Force bit refreshes once then clears.
// - Interval one gives refresh every 32 cycles.
module memctl_reset_init (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_phase_reference,
   input wire logic test_tristate_n,
   output logic [memctl_init_pkg::EDGE_N-1:0] phase_edges,
   output logic outputs_oe,
   output logic cache_data_oe_strobe,
   output logic tag_oe_strobe,
   output logic mem_bus_drive_ctl,
   output logic refresh_strobe,
   output logic presence_detect_start,
   input wire logic [15:0] cache_data_bus_in,
   output logic [15:0] cache_data_bus_out,
   output logic cache_data_bus_oe
);
   import memctl_init_pkg::*;

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic ref_s1;
      logic ref_s2;
      logic ref_prev;
      logic [1:0] phase;
      logic [EDGE_N-1:0] edges;
      apb_st_e st;
      logic [1:0] wcnt;
      logic [31:0] rdata;
      logic force_ref;
      logic by_force;
      logic [IV_W-1:0] interval;
      logic [10:0] timer;
      logic due;
      logic ref_on;
      logic [1:0] busy;
      logic [7:0] ref_cnt;
      logic pd_active;
      logic pd_pulse;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic pin_released;
   logic rst_int_n;
   logic oe_hold_q;
   logic tri_s1_q;
   logic tri_s2_q;
   logic pins_on;
   logic tick;
   logic acc;
   logic wr;
   logic mapped;
   logic start;
   logic expire;
   logic done;
   logic [31:0] rd_word;

   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [10:0] iv_ticks(input logic [IV_W-1:0] iv);
      return 11'(iv) * 11'(REF_UNIT_SYS) - 11'h001;
   endfunction

   function automatic logic [EDGE_N-1:0] edges_of(input logic [1:0] ph);
      logic [EDGE_N-1:0] e;
      e = '0;
      e[E_CLK1R] = ph == PH_CLK1R;
      e[E_CLK1F] = ph == PH_CLK1F;
      e[E_CLK2R] = ph == PH_CLK2R;
      e[E_CLK2F] = ph == PH_CLK2F;
      e[E_MEMR] = (ph == PH_CLK2R) || (ph == PH_CLK2F);
      return e;
   endfunction

   ////////////////////////////////////////////////////////////////////
   reset_release_sync #(
      .STAGES(RST_STAGES),
      .TAP(PIN_RELEASE_STAGE)
   ) u_rst (
      .pclk(pclk),
      .presetn(presetn),
      .pin_released(pin_released),
      .int_rst_n(rst_int_n)
   );

   // These flops carry no reset: the tristate pin and the strobe hold
   // must keep working while the reset pin is low.
   always_ff @(posedge pclk) begin
      tri_s1_q <= test_tristate_n;
      tri_s2_q <= tri_s1_q;
      oe_hold_q <= !pin_released;
   end

   assign pins_on = tri_s2_q;

   ////////////////////////////////////////////////////////////////////
   assign tick = s_q.edges[E_CLK1R];
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign mapped = reg_hit(paddr, ADDR_REF_TIMING) ||
                   reg_hit(paddr, ADDR_STATUS);
   assign start = !s_q.ref_on && (s_q.due || s_q.force_ref);
   assign expire = tick && (s_q.interval != '0) && (s_q.timer == '0);
   assign done = s_q.ref_on && tick && (s_q.busy == REF_BUSY_LAST);

   always_comb begin
      rd_word = '0;
      if (reg_hit(paddr, ADDR_REF_TIMING)) begin
         rd_word[FORCE_BIT] = s_q.force_ref;
         rd_word[IV_LSB +: IV_W] = s_q.interval;
      end else if (reg_hit(paddr, ADDR_STATUS)) begin
         rd_word[CNT_LSB +: CNT_W] = s_q.ref_cnt;
         rd_word[READY_BIT] = s_q.ref_cnt >= INIT_REFRESHES;
         rd_word[PD_BIT] = s_q.pd_active;
      end
   end

   always_comb begin
      s_d = s_q;
      // Phase reference realigns the four-phase counter.
      s_d.ref_s1 = clock_phase_reference;
      s_d.ref_s2 = s_q.ref_s1;
      s_d.ref_prev = s_q.ref_s2;
      if (s_q.ref_s2 && !s_q.ref_prev) begin
         s_d.phase = PH_AFTER_REF;
      end else begin
         s_d.phase = s_q.phase + 2'h1;
      end
      s_d.edges = edges_of(s_d.phase);

      // Reads wait two system cycles before the data is offered.
      case (s_q.st)
         ST_IDLE: begin
            if (psel && !pwrite) begin
               s_d.st = ST_WAIT;
               s_d.wcnt = '0;
            end
         end
         ST_WAIT: begin
            if (tick) begin
               if (s_q.wcnt == CSR_WAIT_LAST) begin
                  s_d.st = ST_DONE;
                  s_d.rdata = rd_word;
               end else begin
                  s_d.wcnt = s_q.wcnt + 2'h1;
               end
            end
         end
         ST_DONE: begin
            if (acc) begin
               s_d.st = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // Presence detect starts on the first cycle out of reset.
      s_d.pd_active = 1'b1;
      s_d.pd_pulse = !s_q.pd_active;

      // Refresh interval timer counts system cycles.
      if (tick && (s_q.interval != '0)) begin
         if (s_q.timer == '0) begin
            s_d.timer = iv_ticks(s_q.interval);
         end else begin
            s_d.timer = s_q.timer - 11'h001;
         end
      end
      s_d.due = (s_q.due && !start) || expire;
      if (start) begin
         s_d.ref_on = 1'b1;
         s_d.busy = '0;
         s_d.by_force = s_q.force_ref && !s_q.due;
      end else if (s_q.ref_on && tick) begin
         if (done) begin
            s_d.ref_on = 1'b0;
         end else begin
            s_d.busy = s_q.busy + 2'h1;
         end
      end
      if (done && (s_q.ref_cnt != REF_CNT_MAX)) begin
         s_d.ref_cnt = s_q.ref_cnt + 8'h01;
      end
      if (done && s_q.by_force) begin
         s_d.force_ref = 1'b0;
      end

      // A software set in the clearing cycle wins over the clear.
      if (wr && reg_hit(paddr, ADDR_REF_TIMING)) begin
         if (pwdata[FORCE_BIT]) begin
            s_d.force_ref = 1'b1;
         end
         s_d.interval = pwdata[IV_LSB +: IV_W];
         s_d.timer = iv_ticks(pwdata[IV_LSB +: IV_W]);
      end
   end

   // The first refresh is already due when internal reset ends.
   always_ff @(posedge pclk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         s_q <= '0;
         // Phase zero is the first rising edge, so its flag must agree.
         s_q.edges[E_CLK1R] <= 1'b1;
         s_q.due <= 1'b1;
         s_q.interval <= IV_RST;
         s_q.timer <= TIMER_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign prdata = s_q.rdata;
   assign pready = pwrite || (s_q.st == ST_DONE);
   assign pslverr = acc && pready && !mapped;
   assign phase_edges = s_q.edges;
   assign outputs_oe = pins_on;
   assign refresh_strobe = s_q.ref_on;
   assign presence_detect_start = s_q.pd_pulse;
   assign mem_bus_drive_ctl = !rst_int_n;
   // Strobes drop on the synchronised pin, two edges before the
   // internal reset lets go.
   assign cache_data_oe_strobe = oe_hold_q && !pin_released;
   assign tag_oe_strobe = oe_hold_q && !pin_released;
   assign cache_data_bus_out = s_q.rdata[15:0];
   assign cache_data_bus_oe = pins_on && rst_int_n &&
                              (s_q.st == ST_DONE);

   ////////////////////////////////////////////////////////////////////
   logic [3:0] wait_len_q;
   logic [7:0] gap_q;
   logic clean_q;
   localparam logic [7:0] GAP_IV1 = 8'(REF_UNIT_SYS * PCLK_PER_SYS - 1);

   always_ff @(posedge pclk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         wait_len_q <= '0;
         gap_q <= '0;
         clean_q <= 1'b0;
      end else begin
         if (s_q.st == ST_WAIT) begin
            wait_len_q <= wait_len_q + 4'h1;
         end else begin
            wait_len_q <= '0;
         end
         if (start) begin
            gap_q <= '0;
         end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
         end
         if (wr || s_q.force_ref) begin
            clean_q <= 1'b0;
         end else if (start && (s_q.interval == 6'h01)) begin
            clean_q <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!rst_int_n);

   a_read_wait_len: assert property (
      (s_q.st == ST_WAIT) && (s_d.st == ST_DONE) |->
      (wait_len_q >= 4'h4) && (wait_len_q <= 4'h7))
      else $error("read answer not after two system cycles");
   a_write_no_wait: assert property (
      wr |-> pready)
      else $error("write access stalled");
   a_force_clears: assert property (
      $rose(s_q.force_ref) && !s_q.ref_on |-> ##[1:10] !s_q.force_ref)
      else $error("force refresh bit not cleared in time");
   a_iv1_period: assert property (
      start && clean_q && (s_q.interval == 6'h01) && !s_q.force_ref
      |-> gap_q == GAP_IV1)
      else $error("interval one does not give 32 system cycles");
   a_edges_phase: assert property (
      $onehot(s_q.edges[3:0]) &&
      (s_q.edges[E_MEMR] == (s_q.edges[E_CLK2R] || s_q.edges[E_CLK2F])))
      else $error("internal edge set malformed");
   a_refresh_begins: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(rst_int_n) |-> ##1 refresh_strobe)
      else $error("no refresh right after reset release");
   a_pd_start_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(rst_int_n) |->
      ##1 presence_detect_start ##1 !presence_detect_start)
      else $error("presence detect start not a single pulse");
   a_reset_quiet: assert property (
      @(posedge pclk) disable iff (1'b0)
      !rst_int_n |-> mem_bus_drive_ctl && !refresh_strobe &&
      !presence_detect_start && !cache_data_bus_oe)
      else $error("pin state wrong during reset");
   a_release_order: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(pin_released) |-> !cache_data_oe_strobe && !rst_int_n
      ##1 !rst_int_n ##1 rst_int_n)
      else $error("strobes or internal reset released out of order");
   a_tristate_float: assert property (
      @(posedge pclk) disable iff (1'b0)
      !pins_on |-> !outputs_oe && !cache_data_bus_oe)
      else $error("outputs driven under test tristate");

   c_read_done: cover property (acc && !pwrite && pready);
   c_force_done: cover property (done && s_q.by_force);
   c_unmapped: cover property (pslverr);
   c_tri_in_reset: cover property (
      @(posedge pclk) !rst_int_n && !pins_on ##1 pins_on);

endmodule
`default_nettype wire

// file: design/reset_release_sync.sv
// Reset synchroniser: asserts at once, releases on pclk.
// Assumes presetn is the board reset pin, asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module reset_release_sync #(
   parameter int unsigned STAGES = 4,
   parameter int unsigned TAP = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic pin_released,
   output logic int_rst_n
);

   logic [STAGES-1:0] chain_q;

   // Every stage clears asynchronously, so the internal reset takes
   // hold without a clock edge and leaves only after the chain fills.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_q <= '0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], 1'b1};
      end
   end

   // The tap sits after two stages, so it is already settled.
   assign pin_released = chain_q[TAP-1];
   assign int_rst_n = chain_q[STAGES-1];

endmodule
`default_nettype wire

// file: verif/board_init_model.sv
// Board-side model: reset pin generator and system phase reference.
// Assumes pclk runs four times per system cycle, as the design does.
`timescale 1ns/1ps
`default_nettype none
module board_init_model #(
   parameter int HOLD_CYCLES = 84
) (
   input wire logic pclk,
   input wire logic rst_req,
   output logic presetn,
   output logic clock_phase_reference
);
   int hold = 0;
   logic [1:0] ph = 2'h0;

   initial begin
      presetn = 1'b0;
      clock_phase_reference = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Twenty system cycles are eighty pclk edges; a few more give margin.
   // Reset stays low past the clock start-up count.
   always @(posedge pclk) begin
      if (rst_req) begin
         presetn <= 1'b0;
         hold <= 0;
      end else if (hold < HOLD_CYCLES) begin
         hold <= hold + 1;
      end else begin
         presetn <= 1'b1;
      end
   end

   // Square wave at the system rate; its rising edge marks phase.
   always @(posedge pclk) begin
      ph <= ph + 2'h1;
      clock_phase_reference <= ph[1];
   end
endmodule
`default_nettype wire

// file: verif/memctl_reset_init_test.sv
// Self-checking bench for the reset and initialization block.
// Assumes the board model owns reset and the phase reference.
`timescale 1ns/1ps
`default_nettype none
module memctl_reset_init_test;
   import memctl_init_pkg::*;
   logic pclk, psel, penable, pwrite, test_tristate_n, rst_req, err;
   logic presetn, clock_phase_reference, pready, pslverr, outputs_oe;
   logic cache_data_oe_strobe, tag_oe_strobe, mem_bus_drive_ctl;
   logic refresh_strobe, presence_detect_start, cache_data_bus_oe, ref_prev;
   logic [7:0] paddr;
   logic [5:0] v;
   logic [31:0] pwdata, prdata, rd, exp_ref;
   logic [15:0] cache_data_bus_in, cache_data_bus_out;
   logic [EDGE_N-1:0] phase_edges;
   int errors = 0, compares = 0, cyc = 0, ref_seen = 0;
   int seed, lat, n, m, p, r, k, j, base;
   int ecnt[EDGE_N];
   int rise_q[$];

   board_init_model board_u (.pclk(pclk), .rst_req(rst_req),
      .presetn(presetn), .clock_phase_reference(clock_phase_reference));

   memctl_reset_init dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clock_phase_reference(clock_phase_reference),
      .test_tristate_n(test_tristate_n), .phase_edges(phase_edges),
      .outputs_oe(outputs_oe), .cache_data_oe_strobe(cache_data_oe_strobe),
      .tag_oe_strobe(tag_oe_strobe), .mem_bus_drive_ctl(mem_bus_drive_ctl),
      .refresh_strobe(refresh_strobe),
      .presence_detect_start(presence_detect_start),
      .cache_data_bus_in(cache_data_bus_in),
      .cache_data_bus_out(cache_data_bus_out),
      .cache_data_bus_oe(cache_data_bus_oe));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Refresh monitor feeds the checks with counts and rise times.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      ref_prev <= refresh_strobe;
      if (refresh_strobe === 1'b1 && ref_prev !== 1'b1) begin
         ref_seen <= ref_seen + 1;
         rise_q.push_back(cyc);
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string what);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   // The answer is taken at the edge that samples pready high, or at the fiftieth edge on timeout.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      lat = 0;
      do begin
         @(posedge pclk);
         lat++;
      end while (pready !== 1'b1 && lat < 50);
      check(lat < 50, 1'b1, "pready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task give_verdict;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 75;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      test_tristate_n = 1'b1;
      rst_req = 1'b0;
      cache_data_bus_in = 16'($random(seed));
      repeat (8) @(posedge pclk);
      #1;
      check(mem_bus_drive_ctl, 1'b1, "mem drive");
      check({cache_data_oe_strobe, tag_oe_strobe}, 2'h3, "strobes");
      check({refresh_strobe, presence_detect_start}, 2'h0, "outs");
      check({cache_data_bus_oe, outputs_oe}, 2'h1, "bus oe");
      @(posedge pclk);
      test_tristate_n <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
      check({outputs_oe, cache_data_bus_oe}, 2'h0, "float");
      @(posedge pclk);
      test_tristate_n <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      check({outputs_oe, mem_bus_drive_ctl, cache_data_oe_strobe,
             tag_oe_strobe}, 4'hF, "back to reset");
      $display("test reset pins done");
      k = 0;
      while (presetn !== 1'b1 && k < 100) begin
         @(posedge pclk);
         k++;
      end
      n = -1; m = -1; p = -1; r = -1;
      for (k = 0; k < 12; k++) begin
         @(posedge pclk);
         #1;
         if (n < 0 && {cache_data_oe_strobe, tag_oe_strobe} === 2'h0) n = k;
         if (m < 0 && mem_bus_drive_ctl === 1'b0) m = k;
         if (p < 0 && presence_detect_start === 1'b1) p = k;
         if (r < 0 && refresh_strobe === 1'b1) r = k;
      end
      check(n >= 0 && n < m, 1'b1, "strobe drop");
      check(m >= 1 && m <= RST_STAGES, 1'b1, "release");
      check(p >= m && p <= m + 1, 1'b1, "detect start");
      check(r >= m && r <= m + 1, 1'b1, "first refresh");
      repeat (10 * PCLK_PER_SYS) @(posedge pclk);
      $display("test release done");
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         #1;
         for (j = 0; j < EDGE_N; j++) if (phase_edges[j] === 1'b1) ecnt[j]++;
      end
      for (j = 0; j < EDGE_N; j++)
         check(ecnt[j], (j == E_MEMR) ? 16 / PCLK_PER_SYS * MEMORY_CLOCK_PER_SYS
                        : 16 / PCLK_PER_SYS, "edge count");
      $display("test phases done");
      exp_ref = 32'(IV_RST) << IV_LSB;
      apb(1'b0, ADDR_REF_TIMING, 32'h0);
      check(rd, exp_ref, "timing reset");
      check(lat > PCLK_PER_SYS && lat <= 3 * PCLK_PER_SYS, 1'b1, "lat");
      apb(1'b0, 8'h08, 32'h0);
      check({err, rd[30:0]}, 32'h80000000, "unmapped read");
      for (k = 0; k < 3; k++) begin
         v = 6'($random(seed));
         if (v == 6'h00) v = 6'h01;
         exp_ref = 32'(v) << IV_LSB;
         apb(1'b1, ADDR_REF_TIMING, exp_ref);
         apb(1'b0, ADDR_REF_TIMING, 32'h0);
         check(rd, exp_ref, "interval readback");
      end
      $display("test registers done");
      apb(1'b1, ADDR_REF_TIMING, 32'h1 << IV_LSB);
      rise_q.delete();
      k = 0;
      while (rise_q.size() < 3 && k < 600) begin
         @(posedge pclk);
         k++;
      end
      check(rise_q.size() >= 3, 1'b1, "refreshes");
      if (rise_q.size() >= 3) begin
         check(rise_q[1] - rise_q[0], REF_UNIT_SYS * PCLK_PER_SYS, "gap");
         check(rise_q[2] - rise_q[1], REF_UNIT_SYS * PCLK_PER_SYS, "gap");
      end
      $display("test minimum interval done");
      apb(1'b1, ADDR_REF_TIMING, 32'h0);
      repeat (20) @(posedge pclk);
      base = ref_seen;
      for (k = 0; k < INIT_REFRESHES; k++) begin
         apb(1'b1, ADDR_REF_TIMING, 32'h1 << FORCE_BIT);
         repeat (10) @(posedge pclk);
         apb(1'b0, ADDR_REF_TIMING, 32'h0);
         check(rd, 32'h0, "force cleared");
      end
      check(ref_seen - base, INIT_REFRESHES, "forced count");
      apb(1'b0, ADDR_STATUS, 32'h0);
      exp_ref = (ref_seen > 255) ? 32'hFF : 32'(ref_seen);
      exp_ref[READY_BIT] = (ref_seen >= INIT_REFRESHES);
      exp_ref[PD_BIT] = 1'b1;
      check(rd, exp_ref, "status");
      // Scrubbing memory with parity lies beyond these pins.
      $display("test forced refresh done");
      @(posedge pclk);
      rst_req <= 1'b1;
      @(posedge pclk);
      rst_req <= 1'b0;
      #1;
      check({mem_bus_drive_ctl, refresh_strobe}, 2'h2, "async reset");
      repeat (4) @(posedge pclk);
      #1;
      check(mem_bus_drive_ctl, 1'b1, "held in reset");
      k = 0;
      while (presetn !== 1'b1 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      check(presetn, 1'b1, "second release wait");
      repeat (RST_STAGES + 1) @(posedge pclk);
      #1;
      check({mem_bus_drive_ctl, refresh_strobe}, 2'h1, "second release");
      $display("test second reset done");
      give_verdict;
   end
endmodule
`default_nettype wire
